// ### hw/ocv_pkg.sv
// Package for the opcode timing and vector map block.
// Assumes one 100 MHz clock and a synchronous program flash interface.
package ocv_pkg;
	// ----------------------------------------------------------------
	// Opcode encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_STOP         = 8'h30;
	localparam logic [7:0] OP_NO_OPERATION = 8'h40;
	localparam logic [7:0] OP_ACC_TO_IDX   = 8'h5c;
	localparam logic [7:0] OP_LOAD_REG     = 8'h5d;
	localparam logic [7:0] OP_WRITE_REG    = 8'h62;
	localparam logic [7:0] OP_RAM_COPY     = 8'h5f;
	localparam logic [7:0] OP_PTR_STORE    = 8'h3f;
	localparam logic [7:0] OP_OR_FLAGS     = 8'h71;
	localparam logic [7:0] OP_XOR_REG_IDX  = 8'h46;
	localparam logic [7:0] OP_COMPLEMENT   = 8'h73;
	localparam logic [7:0] OP_INC_ACC      = 8'h74;
	localparam logic [7:0] OP_DEC_IDX      = 8'h79;
	// ----------------------------------------------------------------
	// Lengths and cycle counts
	// ----------------------------------------------------------------
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [3:0] CYC_4  = 4'h4;
	localparam logic [3:0] CYC_6  = 4'h6;
	localparam logic [3:0] CYC_8  = 4'h8;
	localparam logic [3:0] CYC_9  = 4'h9;
	localparam logic [3:0] CYC_10 = 4'ha;
	localparam logic [3:0] CYC_13 = 4'hd;
	localparam logic [3:0] CYC_ONE = 4'h1;
	// ----------------------------------------------------------------
	// Vector table
	// ----------------------------------------------------------------
	localparam int          NUM_IRQ      = 15; // Supply, 8 blocks, 4 columns, pin, sleep
	localparam logic [13:0] VEC_RESET    = 14'h0000;
	localparam logic [13:0] VEC_SUPPLY   = 14'h0004;
	localparam logic [13:0] VEC_STEP     = 14'h0004;
	localparam logic [13:0] VEC_USER     = 14'h0040;
	localparam logic [13:0] PROG_TOP_MAX = 14'h3fff;
	// Flag bit positions
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 2;
	// ----------------------------------------------------------------
	// Decoded instruction attributes
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       known;  // Opcode in decoded subset
		logic [1:0] len;    // Bytes
		logic [3:0] cyc;    // CPU cycles
		logic       upd_c;  // Carry may change
		logic       upd_z;  // Zero may change
		logic       stop;   // Stop processor
	} ocv_dec_t;
endpackage : ocv_pkg

// ### hw/ocv_prio_enc.sv
// Fixed priority interrupt picker with registered outputs.
// Assumes pending lines are synchronous levels; index 0 is highest.
`timescale 1ns/1ps
`default_nettype none
module ocv_prio_enc #(
	parameter int N = 14
) (
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic [N-1:0]         pend,
	output var  logic                 any_ff,
	output var  logic [$clog2(N)-1:0] idx_ff
);
	// ----------------------------------------------------------------
	// Lowest index wins, i.e. lowest vector address
	// ----------------------------------------------------------------
	logic [$clog2(N)-1:0] nxt_idx; // Winner index
	always_comb begin
		nxt_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pend[i]) begin
				nxt_idx = i[$clog2(N)-1:0];
			end
		end
	end
	// Registered so the vector path stays short
	always_ff @(posedge clk) begin
		if (srst) begin
			any_ff <= 1'b0;
			idx_ff <= '0;
		end else begin
			any_ff <= |pend;
			idx_ff <= nxt_idx;
		end
	end
endmodule : ocv_prio_enc
`default_nettype wire

// ### hw/ocv_decoder.sv
// Instruction decoder, cycle sequencer and vector map of an 8-bit core.
// Assumes flash returns the byte at fetch_addr in the same cycle as the request.
// Function
// - 0x5C accumulator to index, 4 cycles
// - 0x5D register load, 2 bytes, 6, Z
// - 0x62 register immediate write, 3 bytes, 8
// - 0x5F RAM copy, 3 bytes, 10 cycles
// - 0x3F pointer store increment, 2 bytes, 10
// - 0x71 OR flags, 2 bytes, 4, C Z
// - 0x46 XOR indexed register, 3 bytes, 10, Z
// - Acknowledge to vector takes 13 cycles
// - Reset fetch starts at 0x0000
// - Supply monitor vectors to 0x0004
// - Digital blocks vector 0x0008 to 0x0024
// - Analog columns vector 0x0028 to 0x0034
// - Pin 0x0038, sleep timer 0x003C
// - User code begins at 0x0040
// - Program space tops at 0x3FFF
`timescale 1ns/1ps
`default_nettype none
module ocv_decoder #(
	parameter logic [13:0] PROG_TOP = ocv_pkg::PROG_TOP_MAX // Variant top
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  fetch_data,
	input  wire logic        supply_irq,
	input  wire logic [7:0]  digital_block_irq,
	input  wire logic [3:0]  analog_col_irq,
	input  wire logic        gpio_irq,
	input  wire logic        sleep_irq,
	output var  logic [13:0] fetch_addr_ff,
	output var  logic        fetch_req_ff,
	output var  logic [7:0]  opcode_ff,
	output var  ocv_pkg::ocv_dec_t dec_ff,
	output var  logic        retire_ff,
	output var  logic        halted_ff,
	output var  logic        irq_ack_ff,
	output var  logic        vector_taken_ff
);
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {FETCH, WAIT, EXEC, VECT} ocv_state_t;
	ocv_state_t  state_ff;
	ocv_state_t  nxt_state;
	logic [3:0]  cnt_ff;   // Cycles left in current action
	logic [13:0] pc_ff;    // Instruction counter
	// ----------------------------------------------------------------
	// Interrupt request collection, order = vector order
	// ----------------------------------------------------------------
	logic [ocv_pkg::NUM_IRQ-1:0] pend;
	logic                        irq_any;
	logic [3:0]                  irq_idx;
	assign pend = {sleep_irq, gpio_irq, analog_col_irq, digital_block_irq, supply_irq};
	ocv_prio_enc #(.N(ocv_pkg::NUM_IRQ)) u_prio (
		.clk    (clk),
		.srst   (srst),
		.pend   (pend),
		.any_ff (irq_any),
		.idx_ff (irq_idx)
	);
	// Vector address: supply first, then four-byte steps upward
	logic [13:0] irq_vec;
	assign irq_vec = ocv_pkg::VEC_SUPPLY + 14'(irq_idx) * ocv_pkg::VEC_STEP;
	// ----------------------------------------------------------------
	// Opcode decode table
	// ----------------------------------------------------------------
	ocv_pkg::ocv_dec_t dec;
	always_comb begin
		dec = '{known: 1'b1, len: ocv_pkg::LEN_1, cyc: ocv_pkg::CYC_4,
			upd_c: 1'b0, upd_z: 1'b0, stop: 1'b0};
		case (fetch_data)
			ocv_pkg::OP_STOP: begin
				dec.cyc  = ocv_pkg::CYC_9;
				dec.stop = 1'b1;
			end
			ocv_pkg::OP_NO_OPERATION: begin
				dec.cyc = ocv_pkg::CYC_4;
			end
			ocv_pkg::OP_ACC_TO_IDX: begin
				dec.cyc = ocv_pkg::CYC_4;
			end
			ocv_pkg::OP_LOAD_REG: begin
				dec.len   = ocv_pkg::LEN_2;
				dec.cyc   = ocv_pkg::CYC_6;
				dec.upd_z = 1'b1;
			end
			ocv_pkg::OP_WRITE_REG: begin
				dec.len = ocv_pkg::LEN_3;
				dec.cyc = ocv_pkg::CYC_8;
			end
			ocv_pkg::OP_RAM_COPY: begin
				dec.len = ocv_pkg::LEN_3;
				dec.cyc = ocv_pkg::CYC_10;
			end
			ocv_pkg::OP_PTR_STORE: begin
				dec.len = ocv_pkg::LEN_2;
				dec.cyc = ocv_pkg::CYC_10;
			end
			ocv_pkg::OP_OR_FLAGS: begin
				dec.len   = ocv_pkg::LEN_2;
				dec.upd_c = 1'b1;
				dec.upd_z = 1'b1;
			end
			ocv_pkg::OP_XOR_REG_IDX: begin
				dec.len   = ocv_pkg::LEN_3;
				dec.cyc   = ocv_pkg::CYC_10;
				dec.upd_z = 1'b1;
			end
			ocv_pkg::OP_COMPLEMENT: begin
				dec.upd_z = 1'b1;
			end
			ocv_pkg::OP_INC_ACC, ocv_pkg::OP_DEC_IDX: begin
				dec.upd_c = 1'b1;
				dec.upd_z = 1'b1;
			end
			default: begin
				// Outside the subset: treated as a one-byte four-cycle slot
				dec.known = 1'b0;
			end
		endcase
	end
	// ----------------------------------------------------------------
	// Next counter value, wrapped at the variant top
	// ----------------------------------------------------------------
	logic [14:0] pc_sum; // One spare bit so a step past the full space is seen
	logic [13:0] pc_adv;
	assign pc_sum = {1'b0, pc_ff} + {13'h0000, dec_ff.len};
	assign pc_adv = (pc_sum > {1'b0, PROG_TOP}) ? ocv_pkg::VEC_RESET
		: pc_sum[13:0];
	logic last_cyc;
	assign last_cyc = (cnt_ff == ocv_pkg::CYC_ONE);
	// ----------------------------------------------------------------
	// State transitions
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			FETCH: nxt_state = WAIT;
			WAIT:  nxt_state = EXEC;
			EXEC: begin
				if (last_cyc && !dec_ff.stop) begin
					nxt_state = irq_any ? VECT : FETCH;
				end
			end
			VECT: if (last_cyc) nxt_state = FETCH;
			default: nxt_state = FETCH;
		endcase
	end
	// ----------------------------------------------------------------
	// Sequencer registers; stop holds until reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff        <= FETCH;
			pc_ff           <= ocv_pkg::VEC_RESET;
			cnt_ff          <= '0;
			fetch_addr_ff   <= ocv_pkg::VEC_RESET;
			fetch_req_ff    <= 1'b0;
			opcode_ff       <= '0;
			dec_ff          <= '0;
			retire_ff       <= 1'b0;
			halted_ff       <= 1'b0;
			irq_ack_ff      <= 1'b0;
			vector_taken_ff <= 1'b0;
		end else begin
			state_ff        <= nxt_state;
			fetch_req_ff    <= (state_ff == FETCH);
			fetch_addr_ff   <= pc_ff;
			retire_ff       <= 1'b0;
			irq_ack_ff      <= 1'b0;
			vector_taken_ff <= 1'b0;
			case (state_ff)
				WAIT: begin
					// Opcode arrives; total counted from the fetch cycle
					opcode_ff <= fetch_data;
					dec_ff    <= dec;
					cnt_ff    <= dec.cyc - 4'h2;
				end
				EXEC: begin
					if (!last_cyc) begin
						cnt_ff <= cnt_ff - 4'h1;
					end else if (dec_ff.stop) begin
						halted_ff <= 1'b1;
						// One pulse only, not one per halted cycle
						retire_ff <= !halted_ff;
					end else begin
						retire_ff <= 1'b1;
						pc_ff     <= pc_adv;
						if (irq_any) begin
							irq_ack_ff <= 1'b1;
							cnt_ff     <= ocv_pkg::CYC_13 - 4'h1;
						end
					end
				end
				VECT: begin
					if (!last_cyc) begin
						cnt_ff <= cnt_ff - 4'h1;
					end else begin
						pc_ff           <= irq_vec;
						vector_taken_ff <= 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_ack_to_vector;
		@(posedge clk) disable iff (srst)
		$rose(irq_ack_ff) |-> ##13 (fetch_req_ff && !vector_taken_ff) or ##12 vector_taken_ff;
	endproperty
	a_ack_to_vector: assert property (p_ack_to_vector) else $error("vector timing wrong");
	property p_reset_fetch;
		@(posedge clk) $fell(srst) |-> ##1 (fetch_req_ff && fetch_addr_ff == 14'h0000);
	endproperty
	a_reset_fetch: assert property (p_reset_fetch) else $error("reset fetch not at zero");
	property p_vec_range;
		@(posedge clk) disable iff (srst)
		vector_taken_ff |-> (pc_ff >= 14'h0004 && pc_ff <= 14'h003c && pc_ff[1:0] == 2'h0);
	endproperty
	a_vec_range: assert property (p_vec_range) else $error("vector outside table");
	property p_supply_first;
		@(posedge clk) disable iff (srst)
		(irq_ack_ff && $past(supply_irq, 2)) |-> ##12 (pc_ff == 14'h0004);
	endproperty
	a_supply_first: assert property (p_supply_first) else $error("supply vector wrong");
	property p_stop_holds;
		@(posedge clk) disable iff (srst)
		halted_ff |=> halted_ff && !fetch_req_ff;
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stop released");
	property p_nop_len;
		@(posedge clk) disable iff (srst)
		(retire_ff && opcode_ff == 8'h40 && !irq_ack_ff) |->
			pc_ff == (($past(fetch_addr_ff) == PROG_TOP) ? ocv_pkg::VEC_RESET
			: $past(fetch_addr_ff) + 14'h1);
	endproperty
	a_nop_len: assert property (p_nop_len) else $error("length advance wrong");
	property p_nop_cycles;
		@(posedge clk) disable iff (srst)
		(state_ff == WAIT && fetch_data == 8'h40) |-> ##3 retire_ff;
	endproperty
	a_nop_cycles: assert property (p_nop_cycles) else $error("no_operation not 4 cycles");
	property p_copy_cycles;
		@(posedge clk) disable iff (srst)
		(state_ff == WAIT && fetch_data == 8'h5f) |->
			!retire_ff [*8] ##1 !retire_ff ##1 retire_ff;
	endproperty
	a_copy_cycles: assert property (p_copy_cycles) else $error("copy not 10 cycles");
	property p_top;
		@(posedge clk) disable iff (srst) pc_ff <= PROG_TOP;
	endproperty
	a_top: assert property (p_top) else $error("counter past top");
	// Vectors never reach into user code, which starts after the table
	property p_vec_below_user;
		@(posedge clk) disable iff (srst)
		vector_taken_ff |-> pc_ff < ocv_pkg::VEC_USER;
	endproperty
	a_vec_below_user: assert property (p_vec_below_user) else $error("vector in user code");
endmodule : ocv_decoder
`default_nettype wire

// ### test/ocv_flash_model.sv
// Behavioural program flash facing the opcode decoder.
// Assumes one request pulse per opcode fetch; the bench loads mem.
`timescale 1ns/1ps
`default_nettype none
module ocv_flash_model (
	input  wire logic        clk,
	input  wire logic        req,
	input  wire logic [13:0] addr,
	output var  logic [7:0]  data
);
	logic [7:0] mem [0:16383];    // Program bytes
	logic [7:0] last_ff = 8'h00;  // Bus byte of the previous cycle
	logic       hold_ff = 1'b0;   // Byte stays valid one more cycle
	// Outside the valid window the bus toggles, so a late sample
	// never picks up a stale byte by luck
	always_ff @(posedge clk) begin
		hold_ff <= req;
		last_ff <= data;
	end
	assign data = req ? mem[addr] : (hold_ff ? last_ff : ~last_ff);
endmodule : ocv_flash_model
`default_nettype wire

// ### test/tb.sv
// Bench for the opcode decoder: flash model, expectation queues.
// Assumes operands are skipped, never fetched, by the decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [13:0] a;  // Opcode address
		logic [7:0]  op; // Opcode byte
	} ocv_exp_t;
	localparam logic [13:0] TOP = 14'h007f; // Small space keeps wrap short
	logic              clk;
	logic              srst;
	logic [14:0]       irq_v;  // Supply, blocks 0-7, columns 0-3, pin, sleep
	logic [7:0]        fdata;
	logic [13:0]       fa;
	logic              freq, ret, halt, ack, vt;
	logic [7:0]        op;
	ocv_pkg::ocv_dec_t dec;
	int                error_cnt, cmp_count;
	ocv_exp_t          eq[$];  // Instructions yet to retire
	logic [13:0]       vq[$];  // Vectors yet to be fetched

	ocv_decoder #(.PROG_TOP(TOP)) u_ocv_decoder (
		.clk(clk), .srst(srst), .fetch_data(fdata), .supply_irq(irq_v[0]),
		.digital_block_irq(irq_v[8:1]), .analog_col_irq(irq_v[12:9]),
		.gpio_irq(irq_v[13]), .sleep_irq(irq_v[14]), .fetch_addr_ff(fa),
		.fetch_req_ff(freq), .opcode_ff(op), .dec_ff(dec), .retire_ff(ret),
		.halted_ff(halt), .irq_ack_ff(ack), .vector_taken_ff(vt));
	ocv_flash_model u_ocv_flash_model (
		.clk(clk), .req(freq), .addr(fa), .data(fdata));

	function automatic ocv_pkg::ocv_dec_t exp_dec(input logic [7:0] o);
		logic [7:0] f; // Length, cycles, carry, zero
		case (o)
			8'h30: f = {2'h1, 4'h9, 2'h0};
			8'h40: f = {2'h1, 4'h4, 2'h0};
			8'h5c: f = {2'h1, 4'h4, 2'h0};
			8'h5d: f = {2'h2, 4'h6, 2'h1};
			8'h62: f = {2'h3, 4'h8, 2'h0};
			8'h5f: f = {2'h3, 4'ha, 2'h0};
			8'h3f: f = {2'h2, 4'ha, 2'h0};
			8'h71: f = {2'h2, 4'h4, 2'h3};
			8'h46: f = {2'h3, 4'ha, 2'h1};
			8'h73: f = {2'h1, 4'h4, 2'h1};
			8'h74, 8'h79: f = {2'h1, 4'h4, 2'h3};
			default: return {1'b0, 2'h1, 4'h4, 3'h0}; // Unknown: plain 4 cycles
		endcase
		return {1'b1, f, o == 8'h30};
	endfunction : exp_dec

	task automatic chk_val(input string w, input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask : chk_val

	task automatic chk_ins(input ocv_exp_t e, input logic [13:0] a, input int n);
		ocv_pkg::ocv_dec_t x;
		x = exp_dec(e.op);
		chk_val("instr", {a, op, dec, 4'(n)}, {e.a, e.op, x, x.cyc});
	endtask : chk_ins

	// Load one opcode with random operands; the address wraps past TOP
	task automatic put(inout logic [13:0] a, input logic [7:0] o);
		ocv_pkg::ocv_dec_t x;
		x = exp_dec(o);
		u_ocv_flash_model.mem[a] = o;
		eq.push_back('{a, o});
		// Operands stay above 0x7f: a vector may land on one, and a stop there would hang
		for (int k = 1; k < x.len; k++) u_ocv_flash_model.mem[(a + k) & TOP] = {1'b1, 7'($urandom)};
		a = 14'((a + x.len) & TOP);
	endtask : put

	task automatic drain;
		for (int i = 0; i < 3000 && eq.size() > 0; i++) @(posedge clk);
		chk_val("queue left", 40'(eq.size()), 40'h0);
	endtask : drain

	task tally_and_finish;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// Clock, 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Watchdog, well past the few thousand cycles the run needs
	initial begin
		#300000;
		error_cnt++;
		tally_and_finish();
	end

	// Monitor: time each instruction from its fetch, match vectors
	initial begin
		int          cnt, acnt;
		logic [13:0] cur;
		logic        vpend;
		cnt = 0;
		acnt = 0;
		cur = '0;
		vpend = 1'b0;
		forever begin
			@(posedge clk);
			#1;
			cnt++;
			acnt++;
			if (srst === 1'b1) vpend = 1'b0;
			if (freq === 1'b1) begin
				cnt = 1;
				cur = fa;
				if (vpend && vq.size() > 0) chk_val("vector", 40'(fa), 40'(vq.pop_front()));
				vpend = 1'b0;
			end
			if (ack === 1'b1) acnt = 0;
			if (vt === 1'b1) begin
				chk_val("ack to vector", 40'(acnt), 40'd12);
				vpend = 1'b1;
			end
			if (ret === 1'b1 && eq.size() > 0) chk_ins(eq.pop_front(), cur, cnt);
		end
	end

	// Stimulus, driven on falling edges
	initial begin
		logic [13:0] a;
		logic [14:0] m;
		int          i, j, n, bad;
		error_cnt = 0;
		cmp_count = 0;
		srst = 1'b1;
		irq_v = '0;
		void'($urandom(6997));
		// Every decoded opcode except stop (0x30), plus one outside the subset
		for (i = 0; i < 16384; i++) u_ocv_flash_model.mem[i] = 8'h40;
		a = '0;
		put(a, 8'h5c); put(a, 8'h5d); put(a, 8'h62); put(a, 8'h5f);
		put(a, 8'h3f); put(a, 8'h71); put(a, 8'h46); put(a, 8'h73);
		put(a, 8'h74); put(a, 8'h79); put(a, 8'h40); put(a, 8'hff);
		repeat (10) @(negedge clk);
		srst = 1'b0;
		drain();
		// Each source alone, then random mixes where the lowest vector wins
		for (i = 0; i < 21; i++) begin
			m = (i < 15) ? 15'h1 << i : 15'($urandom) | 15'h4000;
			for (j = 14; j >= 0; j--) if (m[j]) n = j;
			vq.push_back(14'(4 + 4 * n));
			@(negedge clk);
			irq_v = m;
			for (j = 0; j < 300 && vt !== 1'b1; j++) begin
				@(posedge clk);
				#1;
			end
			@(negedge clk);
			irq_v = '0;
			repeat (20) @(negedge clk);
		end
		// Reset mid-run, wrap with a two-byte opcode at the top, then stop
		srst = 1'b1;
		for (i = 0; i < 16384; i++) u_ocv_flash_model.mem[i] = 8'h40;
		a = '0;
		while (a != 14'h007f) put(a, 8'h40);
		u_ocv_flash_model.mem[14'h007f] = 8'h5d;
		eq.push_back('{14'h007f, 8'h5d});
		// Stepping past the top lands the counter on zero, not on the carry-over
		eq.push_back('{14'h0000, 8'h40});
		eq.push_back('{14'h0001, 8'h30});
		repeat (10) @(negedge clk);
		srst = 1'b0;
		while (eq.size() > 128) @(negedge clk);
		u_ocv_flash_model.mem[1] = 8'h30;
		drain();
		chk_val("vector left", 40'(vq.size()), 40'h0);
		// Halted: no fetch and no acknowledge, even with a request up
		@(negedge clk);
		irq_v = 15'h0001;
		bad = 0;
		repeat (30) begin
			@(posedge clk);
			#1;
			if (freq !== 1'b0 || ack !== 1'b0) bad = 1;
		end
		chk_val("halt", {halt, 1'(bad)}, 40'h2);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
